// ===== eac_access_ctrl.sv
// Function
// - clear write strobe bit by hardware when programming time ends.
// - stall the core two cycles after the write strobe is set.
// - writing one to read strobe bit reads the addressed location.
// - read byte is in the data register for the next instruction.
// - stall the core four cycles after a read trigger.
// - during programming refuse reads and ignore address writes.
// - time writes from the RC oscillator, 26,368 cycles atomic, 14,400 erase only or write only.
// - write starts only if arm bit set in last four cycles.
// - mode field picks atomic, erase only, write only; 11 reserved.
// - mode writes ignored while strobe set; reset returns 00.
// - ready interrupt asserted while enabled and no write running.
`timescale 1ns/1ps
`default_nettype none
`include "eac_defs.svh"
module eac_access_ctrl
  import eac_pkg::*;
#(
  parameter int ATOM_RC_CYC = `EAC_ATOM_RC_CYC,
  parameter int SPLIT_RC_CYC = `EAC_SPLIT_RC_CYC
)
(
  input wire logic ref_clk, // core/io clock
  input wire logic reset, // async, active high
  input wire eac_bus_req_type bus_req, // register access
  output logic [7:0] rd_data, // read data, cycle after rd
  output eac_core_type core_ctl, // stall and busy to core
  output logic ready_irq, // level, ready interrupt
  output logic irq // level, masked sticky events
);

  localparam int RCW = 15;
  localparam int RCDIV = `EAC_RC_DIV;
  localparam logic [RCW-1:0] ATOM_N = RCW'(ATOM_RC_CYC);
  localparam logic [RCW-1:0] SPLIT_N = RCW'(SPLIT_RC_CYC);

  // cell array, no reset: cells keep their contents like real storage
  logic [7:0] mem_q [0:`EAC_DEPTH-1];

  // software-visible registers
  logic [`EAC_AW-1:0] addr_q;
  logic [7:0] data_q;
  logic [7:0] rd_data_q;
  eac_mode_type mode_q;
  logic rie_q;
  logic arm_q;
  logic [2:0] arm_cnt_q;

  // programming timer on the rc rate
  logic busy_q;
  logic [RCW-1:0] rc_left_q;
  logic [2:0] rc_div_q;
  logic rc_tick;

  // core stall counter
  logic [2:0] stall_q;

  // operation captured at write start
  logic [`EAC_AW-1:0] op_addr_q;
  logic [7:0] op_data_q;
  eac_mode_type op_mode_q;

  // sticky events, their mask and this cycle's events
  logic [`EAC_ST_W-1:0] stat_q;
  logic [`EAC_ST_W-1:0] mask_q;
  logic [`EAC_ST_W-1:0] ev;

  // decoded bus strobes
  logic ctl_wr;
  logic rd_trig;
  logic wr_start;
  logic wr_done;
  logic strobe_req;

  // decoded accesses
  assign ctl_wr = bus_req.wr && (bus_req.addr == `EAC_OFS_CTRL);
  assign strobe_req = ctl_wr && bus_req.wdata[`EAC_CTL_WE];
  // arm must already stand before this write; busy blocks a restart
  assign wr_start = strobe_req && arm_q && !busy_q
                    && (mode_q != EAC_PM_RSVD);
  // reads are refused while programming
  assign rd_trig = ctl_wr && bus_req.wdata[`EAC_CTL_RE]
                   && !busy_q;
  assign wr_done = busy_q && rc_tick
                   && (rc_left_q == RCW'(1));

  // rc oscillator rate as an enable pulse
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      rc_div_q <= 3'h0;
    end
    else if (rc_div_q == 3'(RCDIV - 1))
    begin
      rc_div_q <= 3'h0;
    end
    else
    begin
      rc_div_q <= rc_div_q + 3'h1;
    end
  end

  assign rc_tick = (rc_div_q == 3'(RCDIV - 1));

  // arm bit and its four-cycle window
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      arm_q <= 1'b0;
      arm_cnt_q <= 3'h0;
    end
    else if (ctl_wr)
    begin
      arm_q <= bus_req.wdata[`EAC_CTL_ARM];
      arm_cnt_q <= 3'(`EAC_ARM_WIN);
    end
    else if (arm_q)
    begin
      if (arm_cnt_q == 3'h1)
      begin
        arm_q <= 1'b0;
      end
      arm_cnt_q <= arm_cnt_q - 3'h1;
    end
  end

  // mode and ready enable bits
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      mode_q <= eac_mode_type'(`EAC_RST_MODE);
      rie_q <= 1'b0;
    end
    else if (ctl_wr)
    begin
      rie_q <= bus_req.wdata[`EAC_CTL_RIE];
      // mode frozen while a write runs
      if (!busy_q)
      begin
        mode_q <= eac_mode_type'(
          bus_req.wdata[`EAC_CTL_PM_HI:`EAC_CTL_PM_LO]);
      end
    end
  end

  // programming timer; the strobe bit reads as busy
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      busy_q <= 1'b0;
      rc_left_q <= '0;
    end
    else if (wr_start)
    begin
      busy_q <= 1'b1;
      rc_left_q <= (mode_q == EAC_PM_ATOMIC) ? ATOM_N
                                              : SPLIT_N;
    end
    else if (busy_q && rc_tick)
    begin
      rc_left_q <= rc_left_q - RCW'(1);
      if (rc_left_q == RCW'(1))
      begin
        busy_q <= 1'b0;
      end
    end
  end

  // operation latched at start so later bus writes cannot disturb it
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      op_addr_q <= '0;
      op_data_q <= `EAC_RST_BYTE;
      op_mode_q <= EAC_PM_ATOMIC;
    end
    else if (wr_start)
    begin
      op_addr_q <= addr_q;
      op_data_q <= data_q;
      op_mode_q <= mode_q;
    end
  end

  // cell array update at the end of programming
  always_ff @(posedge ref_clk)
  begin
    if (wr_done)
    begin
      unique case (op_mode_q)
        EAC_PM_ATOMIC: mem_q[op_addr_q] <= op_data_q;
        EAC_PM_ERASE: mem_q[op_addr_q] <= `EAC_ERASED;
        // write only can clear bits, never set them
        EAC_PM_WRITE: mem_q[op_addr_q] <= mem_q[op_addr_q] & op_data_q;
        EAC_PM_RSVD: mem_q[op_addr_q] <= mem_q[op_addr_q];
      endcase
    end
  end

  // address register, locked while programming
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      addr_q <= '0;
    end
    else if (bus_req.wr && !busy_q)
    begin
      if (bus_req.addr == `EAC_OFS_ADRL)
      begin
        addr_q[7:0] <= bus_req.wdata;
      end
      else if (bus_req.addr == `EAC_OFS_ADRH)
      begin
        addr_q[8] <= bus_req.wdata[0];
      end
    end
  end

  // data register: software write or fetched byte
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      data_q <= `EAC_RST_BYTE;
    end
    else if (rd_trig)
    begin
      data_q <= mem_q[addr_q];
    end
    else if (bus_req.wr && (bus_req.addr == `EAC_OFS_DATA))
    begin
      data_q <= bus_req.wdata;
    end
  end

  // stall counter; a read outlasts a write start
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      stall_q <= 3'h0;
    end
    else if (rd_trig)
    begin
      stall_q <= 3'(`EAC_RD_STALL);
    end
    else if (wr_start)
    begin
      stall_q <= 3'(`EAC_WR_STALL);
    end
    else if (stall_q != 3'h0)
    begin
      stall_q <= stall_q - 3'h1;
    end
  end

  // whole carrier in one assignment, so it has a single driver
  assign core_ctl = '{stall: (stall_q != 3'h0), busy: busy_q};

  // events for the sticky status
  always_comb
  begin
    ev = '0;
    ev[`EAC_ST_WDONE] = wr_done;
    ev[`EAC_ST_RDONE] = rd_trig;
    ev[`EAC_ST_REFUSE] = (strobe_req && !wr_start)
      || (ctl_wr && bus_req.wdata[`EAC_CTL_RE] && busy_q);
  end

  // status clears on read; a new event wins over the clear
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      stat_q <= '0;
    end
    else if (bus_req.rd && (bus_req.addr == `EAC_OFS_STAT))
    begin
      stat_q <= ev;
    end
    else
    begin
      stat_q <= stat_q | ev;
    end
  end

  // interrupt mask
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      mask_q <= `EAC_RST_MASK;
    end
    else if (bus_req.wr && (bus_req.addr == `EAC_OFS_MASK))
    begin
      mask_q <= bus_req.wdata[`EAC_ST_W-1:0];
    end
  end

  assign irq = |(stat_q & mask_q);
  assign ready_irq = rie_q && !busy_q;

  // read data, valid only in the cycle after the strobe
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      rd_data_q <= 8'h00;
    end
    else if (bus_req.rd)
    begin
      unique case (bus_req.addr)
        `EAC_OFS_CTRL: rd_data_q <= {2'h0, mode_q, rie_q, arm_q,
                                     busy_q, 1'b0};
        `EAC_OFS_DATA: rd_data_q <= data_q;
        `EAC_OFS_ADRL: rd_data_q <= addr_q[7:0];
        `EAC_OFS_ADRH: rd_data_q <= {7'h00, addr_q[8]};
        `EAC_OFS_STAT: rd_data_q <= {5'h00, stat_q};
        `EAC_OFS_MASK: rd_data_q <= {5'h00, mask_q};
        default: rd_data_q <= 8'h00;
      endcase
    end
    else
    begin
      rd_data_q <= 8'h00;
    end
  end

  assign rd_data = rd_data_q;

endmodule // eac_access_ctrl
`default_nettype wire

// ===== eac_defs.svh
`ifndef EAC_DEFS_SVH
`define EAC_DEFS_SVH
// register offsets
`define EAC_OFS_CTRL 8'h1F
`define EAC_OFS_DATA 8'h20
`define EAC_OFS_ADRL 8'h21
`define EAC_OFS_ADRH 8'h22
`define EAC_OFS_STAT 8'h23
`define EAC_OFS_MASK 8'h24
// control register fields
`define EAC_CTL_RE 0
`define EAC_CTL_WE 1
`define EAC_CTL_ARM 2
`define EAC_CTL_RIE 3
`define EAC_CTL_PM_LO 4
`define EAC_CTL_PM_HI 5
// status and mask fields
`define EAC_ST_WDONE 0
`define EAC_ST_RDONE 1
`define EAC_ST_REFUSE 2
`define EAC_ST_W 3
// reset values and the erased byte
`define EAC_RST_MODE 2'h0
`define EAC_RST_MASK 3'h0
`define EAC_RST_BYTE 8'h00
`define EAC_ERASED 8'hFF
// timing
`define EAC_CLK_KHZ 40000
`define EAC_RC_KHZ 8000
`define EAC_WR_STALL 2
`define EAC_RD_STALL 4
`define EAC_ARM_WIN 4
`define EAC_ATOM_RC_CYC 26368
`define EAC_SPLIT_TIME_US 1800
`define EAC_SPLIT_RC_CYC (`EAC_SPLIT_TIME_US * `EAC_RC_KHZ / 1000)
`define EAC_RC_DIV (`EAC_CLK_KHZ / `EAC_RC_KHZ)
// sizes
`define EAC_AW 9
`define EAC_DEPTH 512
`endif

// ===== eac_pkg.sv
`default_nettype none
package eac_pkg;
  // programming action selected by the mode field
  typedef enum logic [1:0] {
    EAC_PM_ATOMIC,
    EAC_PM_ERASE,
    EAC_PM_WRITE,
    EAC_PM_RSVD
  } eac_mode_type;
  // register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } eac_bus_req_type;
  // core-side status
  typedef struct packed {
    logic stall;
    logic busy;
  } eac_core_type;
endpackage
`default_nettype wire

// ===== eac_access_ctrl_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "eac_defs.svh"
module eac_access_ctrl_monitor
  import eac_pkg::*;
#(
  parameter int ATOM_RC_CYC = 8,
  parameter int SPLIT_RC_CYC = 4
)
(
  input wire logic ref_clk, // clock
  input wire logic reset, // async reset
  input wire eac_bus_req_type bus_req, // bus request
  input wire logic [7:0] rd_data, // read data
  input wire eac_core_type core_ctl, // stall, busy
  input wire logic ready_irq, // ready irq
  input wire logic irq // event irq
);
  // first rc tick comes 1..div cycles after start, the rest div apart
  localparam int MINB = SPLIT_RC_CYC * `EAC_RC_DIV - (`EAC_RC_DIV - 1);
  localparam int MAXB = ATOM_RC_CYC * `EAC_RC_DIV;
  logic cw;
  logic [4:0] arm_q;
  int bcnt_q;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // control register writes
  assign cw = bus_req.wr && bus_req.addr == `EAC_OFS_CTRL;
  // recent arm writes and length of busy
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      arm_q <= 5'h00;
      bcnt_q <= 0;
    end
    else
    begin
      arm_q <= {arm_q[3:0], cw && bus_req.wdata[2]};
      bcnt_q <= core_ctl.busy ? bcnt_q + 1 : 0;
    end
  end
  property p_wst;
    $rose(core_ctl.busy) |-> core_ctl.stall[*2] ##1 !core_ctl.stall;
  endproperty
  a_wst: assert property (p_wst) else $error("write stall");
  property p_rst;
    cw && bus_req.wdata[0] && !core_ctl.busy
      |=> core_ctl.stall[*4] ##1 !core_ctl.stall;
  endproperty
  a_rst: assert property (p_rst) else $error("read stall");
  property p_tmin;
    $fell(core_ctl.busy) |-> bcnt_q >= MINB;
  endproperty
  a_tmin: assert property (p_tmin) else $error("busy short");
  property p_tmax;
    core_ctl.busy |-> bcnt_q <= MAXB;
  endproperty
  a_tmax: assert property (p_tmax) else $error("busy long");
  property p_rdyb;
    ready_irq |-> !core_ctl.busy;
  endproperty
  a_rdyb: assert property (p_rdyb) else $error("ready in busy");
  property p_rdyon;
    cw && bus_req.wdata[3] && !bus_req.wdata[1] && !core_ctl.busy
      |=> ready_irq;
  endproperty
  a_rdyon: assert property (p_rdyon) else $error("no ready");
  property p_arm;
    $rose(core_ctl.busy) |-> |arm_q[4:1];
  endproperty
  a_arm: assert property (p_arm) else $error("unarmed write");
  property p_stc;
    $rose(core_ctl.stall) |-> $past(cw);
  endproperty
  a_stc: assert property (p_stc) else $error("stray stall");
endmodule // eac_access_ctrl_monitor
bind eac_access_ctrl eac_access_ctrl_monitor #(
  .ATOM_RC_CYC(ATOM_RC_CYC),
  .SPLIT_RC_CYC(SPLIT_RC_CYC)
) eac_access_ctrl_monitor_inst (
  .ref_clk(ref_clk),
  .reset(reset),
  .bus_req(bus_req),
  .rd_data(rd_data),
  .core_ctl(core_ctl),
  .ready_irq(ready_irq),
  .irq(irq)
);
`default_nettype wire

// ===== eac_core_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "eac_defs.svh"
module eac_core_model
  import eac_pkg::*;
(
  input wire logic ref_clk, // clock
  input wire logic [7:0] rd_data, // read data
  output eac_bus_req_type bus_req // requests
);
  // idle bus; no flash store, no interrupts here
  initial bus_req = '0;
  // one-cycle write; the gap avoids double drives
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge ref_clk);
    bus_req.wr <= 1'b0;
  endtask
  // read data taken mid-cycle, while it stands after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    bus_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge ref_clk);
    bus_req.rd <= 1'b0;
    @(negedge ref_clk);
    d = rd_data;
  endtask
  // poll write strobe bit, bounded
  task automatic wait_idle(output logic ok);
    logic [7:0] v;
    ok = 1'b0;
    for (int i = 0; i < 100 && !ok; i++)
    begin
      rd(`EAC_OFS_CTRL, v);
      ok = !v[`EAC_CTL_WE];
    end
  endtask
endmodule // eac_core_model
`default_nettype wire

// ===== eac_access_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "eac_defs.svh"
module eac_access_ctrl_tb
  import eac_pkg::*;
;
  localparam logic [7:0] CT = `EAC_OFS_CTRL;
  localparam logic [7:0] DT = `EAC_OFS_DATA;
  localparam logic [7:0] ST = `EAC_OFS_STAT;
  localparam logic [7:0] MK = `EAC_OFS_MASK;
  logic ref_clk, reset, ready_irq, irq, ok;
  logic [7:0] rd_data, v;
  eac_bus_req_type bus_req;
  eac_core_type core_ctl;
  int n_errors, check_count;
  // 40 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // short counts keep the run brief
  eac_access_ctrl #(.ATOM_RC_CYC(8), .SPLIT_RC_CYC(4))
    eac_access_ctrl_inst (
    .ref_clk(ref_clk),
    .reset(reset),
    .bus_req(bus_req),
    .rd_data(rd_data),
    .core_ctl(core_ctl),
    .ready_irq(ready_irq),
    .irq(irq)
  );
  eac_core_model eac_core_model_inst (
    .ref_clk(ref_clk),
    .rd_data(rd_data),
    .bus_req(bus_req)
  );
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // checks land at the falling edge, away from updates
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    eac_core_model_inst.wr(a, d);
    @(negedge ref_clk);
  endtask
  task automatic r(input logic [7:0] a, input logic [7:0] m,
    input logic [7:0] e);
    eac_core_model_inst.rd(a, v);
    @(negedge ref_clk);
    chk(v & m, e);
  endtask
  task automatic idle;
    eac_core_model_inst.wait_idle(ok);
    @(negedge ref_clk);
    chk({7'h00, ok}, 8'h01);
    if (ok !== 1'b1)
      report_and_stop;
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    reset = 1'b1;
    n_errors = 0;
    check_count = 0;
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    r(CT, 8'hFF, 8'h00);
    r(MK, 8'hFF, 8'h00);
    r(8'h30, 8'hFF, 8'h00);
    w(MK, 8'h01);
    $display("test reset done");
    // atomic write, then a barrage while it programs
    w(`EAC_OFS_ADRL, 8'h05);
    w(`EAC_OFS_ADRH, 8'h01);
    w(DT, 8'h5A);
    w(CT, 8'h04);
    w(CT, 8'h02);
    r(CT, 8'hFF, 8'h02);
    w(`EAC_OFS_ADRL, 8'h00);
    w(CT, 8'h20);
    w(CT, 8'h06);
    w(CT, 8'h01);
    chk({7'h00, irq}, 8'h00);
    idle;
    chk({7'h00, irq}, 8'h01);
    r(ST, 8'hFF, 8'h05);
    chk({7'h00, irq}, 8'h00);
    r(CT, 8'h30, 8'h00);
    w(CT, 8'h01);
    r(DT, 8'hFF, 8'h5A);
    $display("test write done");
    // arm left to expire, refusal is masked
    w(CT, 8'h04);
    repeat (6) @(posedge ref_clk);
    w(CT, 8'h02);
    r(CT, 8'h02, 8'h00);
    chk({7'h00, irq}, 8'h00);
    r(ST, 8'hFF, 8'h06);
    $display("test arm done");
    // erase only, write only, reserved
    w(CT, 8'h14);
    w(CT, 8'h16);
    idle;
    w(CT, 8'h01);
    r(DT, 8'hFF, 8'hFF);
    w(DT, 8'h0F);
    w(CT, 8'h2C);
    chk({7'h00, ready_irq}, 8'h01);
    w(CT, 8'h2E);
    chk({7'h00, ready_irq}, 8'h00);
    idle;
    w(CT, 8'h09);
    r(DT, 8'hFF, 8'h0F);
    w(CT, 8'h34);
    w(CT, 8'h36);
    r(CT, 8'h32, 8'h30);
    $display("test modes done");
    report_and_stop;
  end
endmodule // eac_access_ctrl_tb
`default_nettype wire
